// file: dcc_defines.svh
// Purpose: Offsets, field widths, codes and reset values of one DMA channel.
// Assumes: Wishbone classic slave with 32-bit data and byte addresses.
// Notes: Included by the package and by the channel module.
// Behaviour
// - With the top transfer-mode bit clear, the channel clears its enable at block end unless a Wishbone write lands in that cycle.
// - With the top transfer-mode bit set, the enable stays set at block end.
// - Transfer-mode code 010 moves one line per trigger.
// - With three-dim select low, offsets apply only at block end.
// - Address-mode bits four to three pick destination offset register 0 to 3; with bit five set no destination offset applies.
// - Source codes 100 and 101 apply no source offset.
// - A selected offset register is added to the address at block end.
// - Block completion sets the transfer-done flag that backs the interrupt.
// - The done interrupt is raised only while done-interrupt enable is set.
// - Clearing the enable stops the channel and still reports transfer-done.
// - Request-source codes 10011 to 11011 select no hardware request.
// - A word counter loaded with N-1 moves exactly N words per block.
// - At block end the word counter reloads its programmed value.
`ifndef DCC_DEFINES_SVH
`define DCC_DEFINES_SVH
`define DCC_ADR_CTRL 6'h00
`define DCC_ADR_STAT 6'h01
`define DCC_ADR_MASK 6'h02
`define DCC_ADR_CINIT 6'h03
`define DCC_ADR_CNT 6'h04
`define DCC_ADR_LINE 6'h05
`define DCC_ADR_DEST_OFFSET_REG_ZERO 6'h06
`define DCC_ADR_SADR 6'h0A
`define DCC_ADR_DADR 6'h0B
`define DCC_CW 16
`define DCC_AW 24
`define DCC_OW 16
`define DCC_LW 8
`define DCC_RS_RSV_LO 5'h13
`define DCC_RS_RSV_HI 5'h1B
`define DCC_TM_LINE 2'h2
`define DCC_TM_WORD 2'h1
`define DCC_RST_CNT 16'h0000
`define DCC_RST_TM 3'h0
`endif

// file: dcc_pkg.sv
// Purpose: Types shared by the DMA channel modules.
// Assumes: The defines header is included first.
// Notes: State of each module is one packed struct.
`include "dcc_defines.svh"
package dcc_pkg;
	typedef enum logic [0:0] {DCC_IDLE = 1'b0, DCC_RUN = 1'b1} dcc_run_t;
	typedef struct packed {
		logic en;
		logic [2:0] tm;
		logic done_irq_enable;
		logic [4:0] rs;
		logic d3;
		logic [5:0] am;
		logic done;
		logic mask;
		logic [`DCC_CW-1:0] cnt_init;
		logic [`DCC_CW-1:0] cnt;
		logic [`DCC_LW-1:0] line_len;
		logic [`DCC_LW-1:0] line_cnt;
		logic [3:0][`DCC_OW-1:0] dor;
		dcc_run_t st;
		logic ack;
		logic [31:0] rdata;
		logic irq;
		logic xv;
		logic [`DCC_AW-1:0] xs;
		logic [`DCC_AW-1:0] xd;
		logic [`DCC_CW-1:0] words;
	} dcc_state_t;
	typedef struct packed {
		logic [`DCC_AW-1:0] addr;
	} dcc_agen_state_t;
endpackage : dcc_pkg

// file: dcc_agen_if.sv
// Purpose: Carrier between the channel control and an address generator.
// Assumes: One clock domain.
// Notes: Jump adds the offset instead of the unit step.
`timescale 1ns/1ns
interface dcc_agen_if;
	logic load;
	logic [23:0] load_val;
	logic step;
	logic jump;
	logic [15:0] offset;
	logic [23:0] addr;
	modport ctl (output load, load_val, step, jump, offset, input addr);
	modport gen (input load, load_val, step, jump, offset, output addr);
endinterface : dcc_agen_if

// file: dcc_addr_gen.sv
// Purpose: One address register that steps by one or jumps by an offset.
// Assumes: Load and step never come in the same cycle.
// Notes: Offset is sign-extended so buffers may also walk backwards.
`timescale 1ns/1ns
module dcc_addr_gen (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Channel side
	dcc_agen_if.gen ag
);
	import dcc_pkg::*;
	dcc_agen_state_t s;
	dcc_agen_state_t next_s;

	always_comb begin
		next_s = s;
		if (ag.load) begin
			next_s.addr = ag.load_val;
		end else if (ag.step && ag.jump) begin
			next_s.addr = s.addr + {{8{ag.offset[15]}}, ag.offset};
		end else if (ag.step) begin
			next_s.addr = s.addr + 24'h000001;
		end
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ag.addr = s.addr;

	property p_jump;
		@(posedge clock) disable iff (!resetn)
		(ag.step && ag.jump && !ag.load) |=>
			s.addr == $past(s.addr) + {{8{$past(ag.offset[15])}},
			$past(ag.offset)};
	endproperty
	a_jump: assert property (p_jump) else $error("offset jump wrong");
endmodule : dcc_addr_gen

// file: dcc_channel.sv
// Purpose: Control of one DMA channel with a Wishbone register file.
// Assumes: Request lines are one-cycle pulses synchronous to clock.
// Notes: One word moves per clock while the channel runs.
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "dcc_defines.svh"
module dcc_channel (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Request sources
	input wire logic [31:0] req_in,
	// Transfer strobe
	output logic xfer_valid,
	output logic [`DCC_AW-1:0] xfer_src_addr,
	output logic [`DCC_AW-1:0] xfer_dst_addr,
	// Interrupt
	output logic irq
);
	import dcc_pkg::*;
	dcc_state_t s;
	dcc_state_t next_s;
	dcc_agen_if src_ag ();
	dcc_agen_if dst_ag ();
	logic wr;
	logic [5:0] idx;
	logic [31:0] wm;
	logic req_hit;
	logic last;
	logic line_last;
	logic stop;
	logic src_use;
	logic dst_use;
	logic done_set;
	logic sw_stop;

	dcc_addr_gen u_src (.clock(clock), .resetn(resetn), .ag(src_ag));
	dcc_addr_gen u_dst (.clock(clock), .resetn(resetn), .ag(dst_ag));

	// Writes land on the edge that samples ack, as the master expects.
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
	assign idx = wb_adr_i[7:2];
	assign wm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign req_hit = !(s.rs >= `DCC_RS_RSV_LO && s.rs <= `DCC_RS_RSV_HI)
		&& req_in[s.rs];
	assign last = s.cnt == 16'h0000;
	assign line_last = s.line_cnt == 8'h00;
	assign dst_use = !s.am[5];
	assign src_use = !s.am[2];
	assign sw_stop = s.st == DCC_RUN && !s.en;
	assign done_set = (s.st == DCC_RUN && s.en && last) || sw_stop;
	assign stop = last || s.tm[1:0] == `DCC_TM_WORD
		|| (s.tm[1:0] == `DCC_TM_LINE && line_last);

	always_comb begin
		src_ag.load = wr && idx == `DCC_ADR_SADR;
		dst_ag.load = wr && idx == `DCC_ADR_DADR;
		src_ag.load_val = (src_ag.addr & ~wm[23:0]) | (wb_dat_i[23:0] & wm[23:0]);
		dst_ag.load_val = (dst_ag.addr & ~wm[23:0]) | (wb_dat_i[23:0] & wm[23:0]);
		src_ag.step = s.st == DCC_RUN && s.en;
		dst_ag.step = s.st == DCC_RUN && s.en;
		src_ag.offset = s.dor[s.am[1:0]];
		dst_ag.offset = s.dor[s.am[4:3]];
		src_ag.jump = src_use && (last || (s.d3 && line_last));
		dst_ag.jump = dst_use && (last || (s.d3 && line_last));
	end

	always_comb begin
		next_s = s;
		next_s.ack = wb_cyc_i && wb_stb_i && !s.ack;
		next_s.xv = 1'b0;
		next_s.xs = src_ag.addr;
		next_s.xd = dst_ag.addr;
		case (idx)
			`DCC_ADR_CTRL: next_s.rdata = {15'h0000, s.am, s.d3, s.rs,
				s.done_irq_enable, s.tm, s.en};
			`DCC_ADR_STAT: next_s.rdata = {30'h00000000, s.st == DCC_RUN,
				s.done};
			`DCC_ADR_MASK: next_s.rdata = {31'h00000000, s.mask};
			`DCC_ADR_CINIT: next_s.rdata = {16'h0000, s.cnt_init};
			`DCC_ADR_CNT: next_s.rdata = {16'h0000, s.cnt};
			`DCC_ADR_LINE: next_s.rdata = {24'h000000, s.line_len};
			6'h06, 6'h07, 6'h08, 6'h09:
				next_s.rdata = {16'h0000, s.dor[idx[1:0] + 2'h2]};
			`DCC_ADR_SADR: next_s.rdata = {8'h00, src_ag.addr};
			`DCC_ADR_DADR: next_s.rdata = {8'h00, dst_ag.addr};
			default: next_s.rdata = 32'h00000000;
		endcase
		if (wr) begin
			case (idx)
				`DCC_ADR_CTRL: begin
					if (wb_sel_i[0]) begin
						next_s.en = wb_dat_i[0];
						next_s.tm = wb_dat_i[3:1];
						next_s.done_irq_enable = wb_dat_i[4];
					end
					if (wb_sel_i[1]) begin
						next_s.rs = wb_dat_i[9:5];
						next_s.d3 = wb_dat_i[10];
						next_s.am = wb_dat_i[16:11];
					end else if (wb_sel_i[0]) begin
						next_s.rs[2:0] = wb_dat_i[7:5];
					end
					if (wb_sel_i[2]) begin
						next_s.am[5] = wb_dat_i[16];
					end
				end
				`DCC_ADR_MASK: if (wb_sel_i[0]) next_s.mask = wb_dat_i[0];
				`DCC_ADR_CINIT: begin
					next_s.cnt_init = (s.cnt_init & ~wm[15:0])
						| (wb_dat_i[15:0] & wm[15:0]);
					next_s.cnt = (s.cnt_init & ~wm[15:0])
						| (wb_dat_i[15:0] & wm[15:0]);
				end
				`DCC_ADR_LINE: if (wb_sel_i[0]) next_s.line_len = wb_dat_i[7:0];
				6'h06, 6'h07, 6'h08, 6'h09:
					next_s.dor[idx[1:0] + 2'h2] = (s.dor[idx[1:0] + 2'h2]
						& ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
				default: next_s.rdata = next_s.rdata;
			endcase
		end
		next_s.done = done_set || (s.done && !(wr && idx == `DCC_ADR_STAT
			&& wb_sel_i[0] && wb_dat_i[0]));
		case (s.st)
			DCC_IDLE: begin
				if (s.en && req_hit) begin
					next_s.st = DCC_RUN;
					next_s.line_cnt = s.line_len;
				end
			end
			DCC_RUN: begin
				if (!s.en) begin
					next_s.st = DCC_IDLE;
					next_s.words = 16'h0000;
				end else begin
					next_s.xv = 1'b1;
					next_s.words = last ? 16'h0000 : s.words + 16'h0001;
					next_s.cnt = last ? s.cnt_init : s.cnt - 16'h0001;
					next_s.line_cnt = line_last ? s.line_len
						: s.line_cnt - 8'h01;
					if (last && !s.tm[2] && !wr) next_s.en = 1'b0;
					if (stop) next_s.st = DCC_IDLE;
				end
			end
			default: next_s.st = DCC_IDLE;
		endcase
		next_s.irq = next_s.done && s.done_irq_enable && s.mask;
	end

	always_ff @(posedge clock) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.rdata;
	assign irq = s.irq;
	assign xfer_valid = s.xv;
	assign xfer_src_addr = s.xs;
	assign xfer_dst_addr = s.xd;

	sequence s_blk_end;
		s.st == DCC_RUN && s.en && last && !wr;
	endsequence
	property p_clear_en;
		@(posedge clock) disable iff (!resetn)
		s_blk_end and !s.tm[2] |=> !s.en;
	endproperty
	a_clear_en: assert property (p_clear_en) else $error("en kept");
	property p_keep_en;
		@(posedge clock) disable iff (!resetn)
		s_blk_end and s.tm[2] |=> s.en;
	endproperty
	a_keep_en: assert property (p_keep_en) else $error("en lost");
	property p_done;
		@(posedge clock) disable iff (!resetn)
		s_blk_end |=> s.done ##1 s.irq == (s.done_irq_enable && s.mask);
	endproperty
	a_done: assert property (p_done) else $error("done missing");
	property p_irq_gate;
		@(posedge clock) disable iff (!resetn)
		irq |-> $past(s.done_irq_enable) && s.done;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq ungated");
	property p_reload;
		@(posedge clock) disable iff (!resetn)
		s_blk_end |=> s.cnt == s.cnt_init;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload");
	property p_count;
		@(posedge clock) disable iff (!resetn)
		s_blk_end and s.cnt_init == $past(s.cnt_init)
			|-> s.words == s.cnt_init || s.tm[1:0] != 2'h0;
	endproperty
	a_count: assert property (p_count) else $error("word count");
	property p_rsv;
		@(posedge clock) disable iff (!resetn)
		s.st == DCC_IDLE && s.rs >= `DCC_RS_RSV_LO
			&& s.rs <= `DCC_RS_RSV_HI |=> s.st == DCC_IDLE;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved start");
	property p_off_ignore;
		@(posedge clock) disable iff (!resetn)
		s.st == DCC_IDLE && !s.en |=> s.st == DCC_IDLE ##0 !s.xv;
	endproperty
	a_off_ignore: assert property (p_off_ignore) else $error("ran off");
	property p_sw_stop;
		@(posedge clock) disable iff (!resetn)
		sw_stop |=> s.st == DCC_IDLE && s.done && !s.xv;
	endproperty
	a_sw_stop: assert property (p_sw_stop) else $error("stop no done");
	property p_line;
		@(posedge clock) disable iff (!resetn)
		s.st == DCC_RUN && s.en && s.tm[1:0] == 2'h2 && line_last
			|=> s.st == DCC_IDLE;
	endproperty
	a_line: assert property (p_line) else $error("line overrun");
endmodule : dcc_channel

// file: dcc_req_model.sv
// Purpose: Request sources that trigger the DMA channel.
// Assumes: One clock; triggers are one-cycle pulses.
// Notes: Idle lines carry random noise so a wrong select is seen.
`timescale 1ns/1ns
module dcc_req_model (
	// System
	input wire logic clock,
	// Bench control
	input wire logic fire,
	input wire logic [4:0] code,
	input wire logic [31:0] noise,
	// Request lines
	output logic [31:0] req_in
);
	always @(posedge clock) begin
		req_in <= (noise & ~(32'h1 << code)) | ({31'h0, fire} << code);
	end
endmodule : dcc_req_model

// file: dcc_channel_test.sv
// Purpose: Self-checking bench of one DMA channel.
// Assumes: Wishbone answers one cycle after a request is taken.
// Notes: Expected reads and words wait in queues for the monitor.
`timescale 1ns/1ns
module dcc_channel_test;
	import dcc_pkg::*;
	logic clock = 1'h0, resetn = 1'h0, fire = 1'h0;
	logic wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, noise = 32'h0, wb_dat_o, req_in;
	logic wb_ack_o, xfer_valid, irq;
	logic [4:0] code = 5'h00;
	logic [23:0] xfer_src_addr, xfer_dst_addr, s, d;
	logic [15:0] off;
	logic [31:0] rq[$];
	logic [47:0] xq[$];
	int mismatches = 0, checks = 0, nwords = 0, w0, n;
	integer seed = 32'hf374;
	dcc_channel uut (.clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .req_in(req_in), .xfer_valid(xfer_valid),
		.xfer_src_addr(xfer_src_addr), .xfer_dst_addr(xfer_dst_addr),
		.irq(irq));
	dcc_req_model req_src (.clock(clock), .fire(fire), .code(code),
		.noise(noise), .req_in(req_in));
	always #2 clock = ~clock;
	always @(posedge clock) noise <= $random(seed);
	task chk(input string nm, input logic [47:0] seen, input logic [47:0] e);
		checks++;
		if (seen !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, seen);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Reads note their expected value, given as the data argument.
	task wb(input logic [7:0] a, input logic w, input logic [31:0] dt);
		int t;
		t = 0;
		if (!w) rq.push_back(dt);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, dt};
		// Ack is looked at mid-cycle, where it has settled, to avoid a race.
		@(negedge clock);
		while (wb_ack_o !== 1'h1 && t < 20) begin
			@(negedge clock);
			t++;
		end
		if (t == 20) mismatches++;
		@(posedge clock);
		{wb_cyc_i, wb_stb_i} <= 2'h0;
		@(posedge clock);
	endtask : wb
	task trig(input logic [4:0] c);
		{fire, code} <= {1'h1, c};
		@(posedge clock);
		fire <= 1'h0;
		@(posedge clock);
	endtask : trig
	task expw(input int cnt);
		for (int i = 0; i < cnt; i++) xq.push_back({s + 24'(i), d + 24'(i)});
	endtask : expw
	function logic [31:0] ctl(logic en, logic [2:0] tm, logic done_irq_enable,
		logic [4:0] rs, logic [5:0] am);
		return {15'h0, am, 1'h0, rs, done_irq_enable, tm, en};
	endfunction : ctl
	always @(posedge clock) begin
		if (wb_ack_o === 1'h1 && wb_we_i === 1'h0 && rq.size() > 0)
			chk("rdata", wb_dat_o, rq.pop_front());
		if (xfer_valid === 1'h1) begin
			nwords++;
			if (xq.size() == 0) chk("xfer_extra", 1, 0);
			else chk("xfer_addr", {xfer_src_addr, xfer_dst_addr}, xq.pop_front());
		end
	end
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'h1;
		@(posedge clock);
		wb(8'h00, 0, 0);
		wb(8'h10, 0, 0);
		wb(8'h3C, 0, 0);
		chk("irq_rst", irq, 0);
		$display("test reset done");
		// Block mode with auto-clear of the enable.
		n = 1 + ($unsigned($random(seed)) % 4);
		s = $random(seed);
		d = $random(seed);
		wb(8'h08, 1, 1);
		wb(8'h28, 1, {8'h0, s});
		wb(8'h2C, 1, {8'h0, d});
		wb(8'h0C, 1, n - 1);
		wb(8'h00, 1, ctl(1, 3'h0, 1, 5'h05, 6'h24));
		w0 = nwords;
		expw(n);
		trig(5'h05);
		repeat (n + 6) @(posedge clock);
		chk("words", nwords - w0, n);
		chk("irq_on", irq, 1);
		wb(8'h00, 0, ctl(0, 3'h0, 1, 5'h05, 6'h24));
		wb(8'h04, 0, 1);
		wb(8'h10, 0, n - 1);
		wb(8'h04, 1, 1);
		repeat (2) @(posedge clock);
		chk("irq_clr", irq, 0);
		$display("test block done");
		// Line mode, enable kept, each destination offset register in turn.
		for (int k = 0; k < 4; k++) begin
			s = $random(seed);
			d = $random(seed);
			off = 16'h10 * (k + 1);
			wb(8'h18 + 8'(4 * k), 1, {16'h0, off});
			wb(8'h28, 1, {8'h0, s});
			wb(8'h2C, 1, {8'h0, d});
			wb(8'h14, 1, 1);
			wb(8'h0C, 1, 1);
			wb(8'h00, 1, ctl(1, 3'h6, 0, 5'h05, {3'(k), 3'h4}));
			expw(2);
			trig(5'h05);
			repeat (8) @(posedge clock);
			chk("line_left", xq.size(), 0);
			wb(8'h00, 0, ctl(1, 3'h6, 0, 5'h05, {3'(k), 3'h4}));
			wb(8'h04, 0, 1);
			chk("irq_off", irq, 0);
			wb(8'h2C, 0, {8'h0, d + 24'h1 + 24'(off)});
			wb(8'h28, 0, {8'h0, s + 24'h2});
			wb(8'h00, 1, ctl(0, 3'h6, 0, 5'h05, {3'(k), 3'h4}));
			wb(8'h04, 1, 1);
		end
		$display("test offset done");
		// Software stop in mid-block.
		wb(8'h28, 1, {8'h0, s});
		wb(8'h2C, 1, {8'h0, d});
		wb(8'h0C, 1, 15);
		wb(8'h00, 1, ctl(1, 3'h0, 1, 5'h05, 6'h24));
		w0 = nwords;
		expw(16);
		trig(5'h05);
		wb(8'h00, 1, ctl(0, 3'h0, 1, 5'h05, 6'h24));
		repeat (6) @(posedge clock);
		chk("stopped", (nwords - w0) < 16, 1);
		wb(8'h04, 0, 1);
		chk("irq_stop", irq, 1);
		xq.delete();
		wb(8'h04, 1, 1);
		$display("test stop done");
		// Reserved sources and a disabled channel ignore triggers.
		w0 = nwords;
		for (int c = 19; c <= 27; c += 8) begin
			wb(8'h00, 1, ctl(1, 3'h0, 1, 5'(c), 6'h24));
			trig(5'(c));
			repeat (6) @(posedge clock);
		end
		wb(8'h00, 1, ctl(0, 3'h0, 1, 5'h05, 6'h24));
		trig(5'h05);
		repeat (6) @(posedge clock);
		chk("ignored", nwords - w0, 0);
		$display("test ignore done");
		end_sim();
	end
endmodule : dcc_channel_test
